// file: vlc_pkg.sv
package vlc_pkg;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam int         ADDR_W          = 2;
	localparam int         DATA_W          = 8;
	localparam logic [1:0] ADDR_CTRL_ONE   = 2'h0;
	localparam logic [1:0] ADDR_CTRL_TWO   = 2'h1;
	localparam logic [1:0] ADDR_STATE_VEC  = 2'h2;
	localparam logic [1:0] ADDR_LINK_DATA  = 2'h3;

	// link_control_one fields
	localparam int C1_IGNORE     = 7;
	localparam int C1_TIMEBASE   = 6;
	localparam int C1_RATE_HI    = 3;
	localparam int C1_RATE_LO    = 2;
	localparam int C1_IRQ_GATE   = 1;
	localparam int C1_WAIT_CLOCK = 0;

	// link_control_two fields
	localparam int C2_ANALOG_LOOP  = 7;
	localparam int C2_DIGITAL_LOOP = 6;
	localparam int C2_FAST_RX      = 5;
	localparam int C2_NORM_FORMAT  = 4;
	localparam int C2_EOD_REQ      = 3;

	// Reset values
	localparam logic [7:0] CTRL_ONE_RESET = 8'h00;
	localparam logic [7:0] CTRL_TWO_RESET = 8'h00;

	// ----------------------------------------------------------------
	// State vector codes
	// ----------------------------------------------------------------
	localparam logic [7:0] SV_NONE     = 8'h00;
	localparam logic [7:0] SV_TX_EMPTY = 8'h08;
	localparam logic [7:0] SV_BREAK    = 8'h1C;
	localparam logic [7:0] SV_WAKEUP   = 8'h20;

	// ----------------------------------------------------------------
	// Link timebase and idle times
	// ----------------------------------------------------------------
	localparam longint TICK_HZ_INT = 1000000;
	localparam longint TICK_HZ_BIN = 1048576;
	localparam longint EOF_US      = 280;
	localparam longint IFS_US      = 300;
	localparam int     IDLE_W      = 10;

	// Least times round up to whole link ticks
	localparam logic [IDLE_W-1:0] EOF_TICKS_INT =
		IDLE_W'((EOF_US * TICK_HZ_INT + 999999) / 1000000);
	localparam logic [IDLE_W-1:0] EOF_TICKS_BIN =
		IDLE_W'((EOF_US * TICK_HZ_BIN + 999999) / 1000000);
	localparam logic [IDLE_W-1:0] IFS_TICKS_INT =
		IDLE_W'((IFS_US * TICK_HZ_INT + 999999) / 1000000);
	localparam logic [IDLE_W-1:0] IFS_TICKS_BIN =
		IDLE_W'((IFS_US * TICK_HZ_BIN + 999999) / 1000000);

endpackage : vlc_pkg

// file: vlc_rate_div.sv
`timescale 1ns/1ps
`default_nettype none

module vlc_rate_div
	import vlc_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic [1:0] rate,
	input  wire logic       run,
	output var  logic       tick
);

	typedef struct packed {
		logic [2:0] cnt;
		logic       tick;
	} vlc_div_t;

	vlc_div_t st;
	vlc_div_t next_st;
	logic [2:0] last;

	// ----------------------------------------------------------------
	// Divide by 1, 2, 4 or 8
	// ----------------------------------------------------------------
	always_comb begin
		next_st = st;
		last = 3'((4'h1 << rate) - 4'h1);
		next_st.tick = 1'b0;
		if (run) begin
			if (st.cnt >= last) begin
				next_st.cnt = 3'h0;
				next_st.tick = 1'b1;
			end else begin
				next_st.cnt = st.cnt + 3'h1;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign tick = st.tick;

endmodule : vlc_rate_div

`default_nettype wire

// file: vlc_regs.sv
// Added by the designer: the strobed register port and the address map.
`timescale 1ns/1ps
`default_nettype none

module vlc_regs
	import vlc_pkg::*;
(
	input  wire logic              clk,
	input  wire logic              rstn,
	// Register port
	input  wire logic [ADDR_W-1:0] addr,
	input  wire logic [DATA_W-1:0] wdata,
	input  wire logic              wr,
	input  wire logic              rd,
	output var  logic [DATA_W-1:0] rdata,
	// CPU state and interrupt
	input  wire logic              cpu_wait,
	output var  logic              irq,
	// Transceiver side
	input  wire logic              digital_rx_in,
	output var  logic              digital_tx_out,
	output var  logic              bus_drive_en,
	output var  logic              analog_loop_out,
	// Protocol engine side
	input  wire logic              engine_tx_bit,
	input  wire logic              sof_seen,
	input  wire logic              break_seen,
	input  wire logic              eod_valid_seen,
	input  wire logic              crc_first_bit,
	input  wire logic              link_error,
	input  wire logic              ifr_active,
	input  wire logic              ifr_with_crc,
	input  wire logic              tx_empty_evt,
	input  wire logic              sv_evt,
	input  wire logic [7:0]        sv_evt_code,
	output var  logic              engine_rx_bit,
	output var  logic              engine_reset,
	output var  logic              link_tick,
	output var  logic              timebase_select,
	output var  logic              rx_enable,
	output var  logic              tx_enable,
	output var  logic              fast_rx_mode,
	output var  logic              norm_bit,
	output var  logic              eod_req,
	output var  logic [7:0]        tx_byte,
	output var  logic              tx_byte_load
);

	// ----------------------------------------------------------------
	// Reset release
	// ----------------------------------------------------------------
	logic [1:0] rst_sync;
	logic       rst_n;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rst_sync <= 2'b00;
		end else begin
			rst_sync <= {rst_sync[0], 1'b1};
		end
	end

	assign rst_n = rst_sync[1];

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		logic              bus_s1;
		logic              bus_s2;
		logic              bus_prev;
		logic              ignore;
		logic              timebase;
		logic [1:0]        rate;
		logic              rate_locked;
		logic              irq_gate;
		logic              wait_clock;
		logic              analog_loop_control;
		logic              digital_loop_control;
		logic              fast_rx;
		logic              norm_bit_format;
		logic              end_of_data_request;
		logic              tx_empty;
		logic [7:0]        sv;
		logic [IDLE_W-1:0] idle_cnt;
		logic              rx_allow;
		logic              tx_allow;
		logic [7:0]        rdata;
		logic              irq;
		logic              eng_rst;
		logic              link_run;
		logic              rx_en;
		logic              tx_en;
		logic              norm_bit;
		logic              rx_bit;
		logic              drive_en;
		logic              tx_out;
		logic [7:0]        tx_byte;
		logic              tx_load;
	} vlc_state_t;

	vlc_state_t st;
	vlc_state_t next_st;
	logic       tick;

	vlc_rate_div u_div (
		.clk   (clk),
		.rst_n (rst_n),
		.rate  (st.rate),
		.run   (st.link_run),
		.tick  (tick)
	);

	// ----------------------------------------------------------------
	// Elaboration checks
	// ----------------------------------------------------------------
	localparam longint IFS_TICKS_MAX = (IFS_US * TICK_HZ_BIN + 999999) / 1000000;
	localparam longint IDLE_SAT      = (longint'(1) << IDLE_W) - 1;

	// Idle counter saturates at all ones; a least time must stay below that
	if (IFS_TICKS_MAX >= IDLE_SAT) begin : g_idle_chk
		$error("idle counter too narrow for the least idle times");
	end

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	logic              wr_c1;
	logic              wr_c2;
	logic              loop_on;
	logic              loop_clear;
	logic              bus_edge;
	logic              pending;
	logic [IDLE_W-1:0] eof_ticks;
	logic [IDLE_W-1:0] ifs_ticks;
	logic [7:0]        sv_view;

	always_comb begin
		next_st = st;
		wr_c1 = wr && (addr == ADDR_CTRL_ONE);
		wr_c2 = wr && (addr == ADDR_CTRL_TWO);
		next_st.bus_s1 = digital_rx_in;
		next_st.bus_s2 = st.bus_s1;
		next_st.bus_prev = st.bus_s2;
		bus_edge = st.bus_s2 != st.bus_prev;
		next_st.eng_rst = 1'b0;
		next_st.tx_load = 1'b0;

		// Control one
		if (wr_c1) begin
			next_st.ignore = wdata[C1_IGNORE];
			next_st.timebase = wdata[C1_TIMEBASE];
			next_st.irq_gate = wdata[C1_IRQ_GATE];
			next_st.wait_clock = wdata[C1_WAIT_CLOCK];
			if (!st.rate_locked) begin
				next_st.rate = {wdata[C1_RATE_HI], wdata[C1_RATE_LO]};
				next_st.rate_locked = 1'b1;
			end
		end
		// Hardware clear wins over a simultaneous write of the flag
		if (sof_seen || break_seen) begin
			next_st.ignore = 1'b0;
		end

		// Control two
		if (wr_c2) begin
			next_st.analog_loop_control = wdata[C2_ANALOG_LOOP];
			next_st.digital_loop_control = wdata[C2_DIGITAL_LOOP];
			next_st.fast_rx = wdata[C2_FAST_RX];
			next_st.norm_bit_format = wdata[C2_NORM_FORMAT];
			if (wdata[C2_EOD_REQ]) begin
				next_st.end_of_data_request = 1'b1;
				next_st.tx_empty = 1'b0;
			end
			if (wdata[C2_ANALOG_LOOP] && !st.analog_loop_control) begin
				next_st.eng_rst = 1'b1;
			end
		end
		if (break_seen) begin
			next_st.fast_rx = 1'b0;
		end
		if (st.end_of_data_request && !(wr_c2 && wdata[C2_EOD_REQ])) begin
			if (link_error) begin
				next_st.end_of_data_request = 1'b0;
			end else if (ifr_active ? eod_valid_seen : crc_first_bit) begin
				next_st.end_of_data_request = 1'b0;
			end
		end

		// Link data
		if (wr && addr == ADDR_LINK_DATA) begin
			next_st.tx_byte = wdata;
			next_st.tx_load = 1'b1;
			next_st.tx_empty = 1'b0;
		end

		// Status: events beat a clear by read in the same cycle
		if (rd && addr == ADDR_STATE_VEC) begin
			next_st.sv = SV_NONE;
		end
		if (tx_empty_evt) begin
			next_st.tx_empty = 1'b1;
		end
		if (sv_evt && sv_evt_code > next_st.sv) begin
			next_st.sv = sv_evt_code;
		end
		if (break_seen && SV_BREAK > next_st.sv) begin
			next_st.sv = SV_BREAK;
		end
		if (bus_edge && !st.link_run && !st.digital_loop_control) begin
			next_st.sv = SV_WAKEUP;
		end
		if (st.ignore && next_st.ignore) begin
			next_st.tx_empty = 1'b0;
			if (next_st.sv != SV_WAKEUP) begin
				next_st.sv = SV_NONE;
			end
		end

		// Idle qualification after loopback
		loop_on = st.analog_loop_control || st.digital_loop_control;
		loop_clear = (st.analog_loop_control && !next_st.analog_loop_control) || (st.digital_loop_control && !next_st.digital_loop_control);
		eof_ticks = st.timebase ? EOF_TICKS_BIN : EOF_TICKS_INT;
		ifs_ticks = st.timebase ? IFS_TICKS_BIN : IFS_TICKS_INT;
		if (loop_on || loop_clear || st.bus_s2) begin
			next_st.idle_cnt = '0;
		end else if (tick && st.idle_cnt != '1) begin
			next_st.idle_cnt = st.idle_cnt + 1'b1;
		end
		if (loop_on || loop_clear) begin
			next_st.rx_allow = 1'b0;
			next_st.tx_allow = 1'b0;
		end else begin
			if (st.idle_cnt >= eof_ticks) begin
				next_st.rx_allow = 1'b1;
			end
			if (st.idle_cnt >= ifs_ticks) begin
				next_st.tx_allow = 1'b1;
			end
		end

		// Engine controls
		next_st.link_run = !(cpu_wait && st.wait_clock);
		next_st.rx_en = !next_st.ignore && (next_st.rx_allow || next_st.digital_loop_control);
		next_st.tx_en = !next_st.fast_rx && (next_st.tx_allow || next_st.digital_loop_control);
		next_st.norm_bit = ifr_with_crc ^ st.norm_bit_format;
		next_st.rx_bit = st.digital_loop_control ? engine_tx_bit : st.bus_s2;
		next_st.drive_en = !st.analog_loop_control && !st.digital_loop_control;
		// Analog loop keeps feeding the transceiver's loop path;
		// digital loop takes the pin off the line altogether
		next_st.tx_out = !st.digital_loop_control && engine_tx_bit;

		// Interrupt
		pending = (st.sv != SV_NONE) || st.tx_empty;
		next_st.irq = (st.sv == SV_WAKEUP)
			|| (st.irq_gate && pending && !st.ignore);

		// Read data
		sv_view = (st.sv == SV_NONE && st.tx_empty) ? SV_TX_EMPTY : st.sv;
		next_st.rdata = 8'h00;
		if (rd) begin
			unique case (addr)
				ADDR_CTRL_ONE: begin
					next_st.rdata[C1_IGNORE] = st.ignore;
					next_st.rdata[C1_TIMEBASE] = st.timebase;
					next_st.rdata[C1_RATE_HI] = st.rate[1];
					next_st.rdata[C1_RATE_LO] = st.rate[0];
					next_st.rdata[C1_IRQ_GATE] = st.irq_gate;
					next_st.rdata[C1_WAIT_CLOCK] = st.wait_clock;
				end
				ADDR_CTRL_TWO: begin
					next_st.rdata[C2_ANALOG_LOOP] = st.analog_loop_control;
					next_st.rdata[C2_DIGITAL_LOOP] = st.digital_loop_control;
					next_st.rdata[C2_FAST_RX] = st.fast_rx;
					next_st.rdata[C2_NORM_FORMAT] = st.norm_bit_format;
					next_st.rdata[C2_EOD_REQ] = st.end_of_data_request;
				end
				ADDR_STATE_VEC: begin
					next_st.rdata = sv_view;
				end
				ADDR_LINK_DATA: begin
					next_st.rdata = st.tx_byte;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign rdata           = st.rdata;
	assign irq             = st.irq;
	assign digital_tx_out  = st.tx_out;
	assign bus_drive_en    = st.drive_en;
	assign analog_loop_out = st.analog_loop_control;
	assign engine_rx_bit   = st.rx_bit;
	assign engine_reset    = st.eng_rst;
	assign link_tick       = tick;
	assign timebase_select = st.timebase;
	assign rx_enable       = st.rx_en;
	assign tx_enable       = st.tx_en;
	assign fast_rx_mode    = st.fast_rx;
	assign norm_bit        = st.norm_bit;
	assign eod_req         = st.end_of_data_request;
	assign tx_byte         = st.tx_byte;
	assign tx_byte_load    = st.tx_load;

endmodule : vlc_regs

`default_nettype wire

// file: vlc_regs_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module vlc_regs_asserts
	import vlc_pkg::*;
(
	input wire logic       clk,
	input wire logic       rstn,
	input wire logic [1:0] addr,
	input wire logic [7:0] wdata,
	input wire logic       wr,
	input wire logic       digital_tx_out,
	input wire logic       bus_drive_en,
	input wire logic       analog_loop_out,
	input wire logic       break_seen,
	input wire logic       eod_valid_seen,
	input wire logic       crc_first_bit,
	input wire logic       link_error,
	input wire logic       ifr_active,
	input wire logic       engine_reset,
	input wire logic       fast_rx_mode,
	input wire logic       tx_enable,
	input wire logic       eod_req
);
	// ----
	// Properties
	// ----
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	logic two_wr;
	logic eod_set;
	assign two_wr  = wr && addr == ADDR_CTRL_TWO;
	assign eod_set = two_wr && wdata[C2_EOD_REQ];
	// A fresh request beats a clear in the same cycle
	property p_eod_set; eod_set |=> eod_req; endproperty
	a_eod_set: assert property (p_eod_set)
		else $error("end request not raised");
	property p_eod_crc;
		eod_req && !ifr_active && (crc_first_bit || link_error) && !eod_set |=> !eod_req;
	endproperty
	a_eod_crc: assert property (p_eod_crc)
		else $error("end request not dropped");
	property p_eod_ifr;
		eod_req && ifr_active && (eod_valid_seen || link_error) && !eod_set |=> !eod_req;
	endproperty
	a_eod_ifr: assert property (p_eod_ifr)
		else $error("response end request not dropped");
	property p_loop_off;
		two_wr && (wdata[C2_ANALOG_LOOP] || wdata[C2_DIGITAL_LOOP]) |-> ##2 !bus_drive_en;
	endproperty
	a_loop_off: assert property (p_loop_off)
		else $error("bus still driven in loopback");
	// Analog loop still feeds the transceiver; one cycle of overlap on its release
	property p_tx_gated;
		digital_tx_out |-> bus_drive_en || analog_loop_out || $past(analog_loop_out);
	endproperty
	a_tx_gated: assert property (p_tx_gated)
		else $error("transmit without drive enable");
	property p_fast_rx; fast_rx_mode && $past(fast_rx_mode) |-> !tx_enable; endproperty
	a_fast_rx: assert property (p_fast_rx)
		else $error("transmit enabled in fast receive");
	property p_break; break_seen |=> !fast_rx_mode; endproperty
	a_break: assert property (p_break)
		else $error("fast receive kept after break");
	property p_eng_rst; engine_reset |-> analog_loop_out ##1 !engine_reset; endproperty
	a_eng_rst: assert property (p_eng_rst)
		else $error("engine reset not a loop entry pulse");
	c_eod: cover property (eod_set ##1 eod_req);
	c_brk: cover property (fast_rx_mode && break_seen);
	c_rst: cover property (engine_reset);
endmodule : vlc_regs_asserts
bind vlc_regs vlc_regs_asserts u_chk (
	.clk, .rstn, .addr, .wdata, .wr, .digital_tx_out, .bus_drive_en,
	.analog_loop_out, .break_seen, .eod_valid_seen, .crc_first_bit,
	.link_error, .ifr_active, .engine_reset, .fast_rx_mode, .tx_enable, .eod_req
);
`default_nettype wire

// file: vlc_bus_model.sv
`timescale 1ns/1ps
`default_nettype none
module vlc_bus_model (
	input  wire logic clk,
	input  wire logic digital_tx_out,
	input  wire logic analog_loop_out,
	input  wire logic node_drive,
	output var  logic digital_rx_in
);
	// ----
	// Wired-OR bus, active high
	// ----
	initial digital_rx_in = 1'h0;
	// Analog loopback returns only our drive stage, other nodes unseen
	always @(posedge clk) begin
		digital_rx_in <= analog_loop_out ? digital_tx_out : digital_tx_out | node_drive;
	end
endmodule : vlc_bus_model
`default_nettype wire

// file: vlc_tb.sv
`timescale 1ns/1ps
`default_nettype none
module testbench
	import vlc_pkg::*;
;
	// ----
	// Signals
	// ----
	logic       clk = 1'h0;
	logic       rstn = 1'h0;
	logic [1:0] addr = 2'h0;
	logic [7:0] wdata = 8'h00;
	logic       wr = 1'h0;
	logic       rd = 1'h0;
	logic       cpu_wait = 1'h0;
	logic       engine_tx_bit = 1'h0;
	logic       ifr_active = 1'h0;
	logic       ifr_with_crc = 1'h0;
	logic       node_drive = 1'h0;
	logic [7:0] sv_evt_code = 8'h00;
	logic [6:0] ev = 7'h00;
	logic [7:0] rdata, tx_byte;
	logic       irq, digital_rx_in, digital_tx_out, bus_drive_en, analog_loop_out;
	logic       engine_rx_bit, engine_reset, link_tick, timebase_select, rx_enable;
	logic       tx_enable, fast_rx_mode, norm_bit, eod_req, tx_byte_load;
	wire logic  sof_seen, break_seen, eod_valid_seen, crc_first_bit;
	wire logic  link_error, tx_empty_evt, sv_evt;
	int         failures = 0;
	int         checked = 0;
	assign {sv_evt, tx_empty_evt, link_error, crc_first_bit} = ev[6:3];
	assign {eod_valid_seen, break_seen, sof_seen} = ev[2:0];
	always #5 clk = ~clk;
	vlc_regs uut (
		.clk, .rstn, .addr, .wdata, .wr, .rd, .rdata, .cpu_wait, .irq,
		.digital_rx_in, .digital_tx_out, .bus_drive_en, .analog_loop_out,
		.engine_tx_bit, .sof_seen, .break_seen, .eod_valid_seen, .crc_first_bit,
		.link_error, .ifr_active, .ifr_with_crc, .tx_empty_evt, .sv_evt, .sv_evt_code,
		.engine_rx_bit, .engine_reset, .link_tick, .timebase_select, .rx_enable,
		.tx_enable, .fast_rx_mode, .norm_bit, .eod_req, .tx_byte, .tx_byte_load
	);
	vlc_bus_model u_bus (.clk, .digital_tx_out, .analog_loop_out, .node_drive, .digital_rx_in);
	// ----
	// Tasks
	// ----
	task test_done;
		$display("checked %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : test_done
	task chk8(input string n, input logic [7:0] e, input logic [7:0] g);
		checked++;
		if (g !== e) begin
			failures++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask : chk8
	task chk1(input string n, input logic e, input logic g);
		chk8(n, {7'h00, e}, {7'h00, g});
	endtask : chk1
	task cycles(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask : cycles
	task do_reset;
		@(posedge clk);
		rstn <= 1'h0;
		repeat (3) @(posedge clk);
		rstn <= 1'h1;
		repeat (3) @(posedge clk);
	endtask : do_reset
	task wr_reg(input logic [1:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'h1;
		@(posedge clk);
		wr <= 1'h0;
		#1;
	endtask : wr_reg
	task rd_reg(input logic [1:0] a, input logic [7:0] e);
		@(posedge clk);
		addr <= a;
		rd <= 1'h1;
		@(posedge clk);
		rd <= 1'h0;
		#1;
		chk8("rdata", e, rdata);
	endtask : rd_reg
	task pulse(input int i);
		@(posedge clk);
		ev[i] <= 1'h1;
		@(posedge clk);
		ev <= 7'h00;
		#1;
	endtask : pulse
	task wait_sig(input logic s, output int n);
		n = 0;
		do begin
			@(posedge clk);
			#1;
			n++;
			if (n > 4000) begin
				failures++;
				test_done();
			end
		end while ((s ? tx_enable : link_tick) !== 1'h1);
	endtask : wait_sig
	task count_ticks(output int k);
		k = 0;
		repeat (16) begin
			@(posedge clk);
			#1;
			k += int'(link_tick);
		end
	endtask : count_ticks
	task t_rate;
		int n;
		for (int c = 0; c < 4; c++) begin
			do_reset();
			rd_reg(ADDR_CTRL_ONE, CTRL_ONE_RESET);
			rd_reg(ADDR_STATE_VEC, SV_NONE);
			wr_reg(ADDR_CTRL_ONE, 8'h40 | 8'(c << 2));
			cycles(2);
			chk1("timebase", 1'h1, timebase_select);
			wr_reg(ADDR_CTRL_ONE, 8'(~c << 2) & 8'h0C);
			rd_reg(ADDR_CTRL_ONE, 8'(c << 2));
			cycles(10);
			wait_sig(1'h0, n);
			wait_sig(1'h0, n);
			chk8("tick gap", 8'(1 << c), 8'(n));
		end
	endtask : t_rate
	task t_eod;
		wr_reg(ADDR_LINK_DATA, 8'h5A);
		chk1("tx_byte_load", 1'h1, tx_byte_load);
		chk8("tx_byte", 8'h5A, tx_byte);
		rd_reg(ADDR_LINK_DATA, 8'h5A);
		pulse(5);
		rd_reg(ADDR_STATE_VEC, SV_TX_EMPTY);
		wr_reg(ADDR_CTRL_TWO, 8'h08);
		chk1("eod_req", 1'h1, eod_req);
		rd_reg(ADDR_STATE_VEC, SV_NONE);
		pulse(3);
		chk1("eod_req", 1'h0, eod_req);
		@(posedge clk);
		ifr_active <= 1'h1;
		wr_reg(ADDR_CTRL_TWO, 8'h08);
		pulse(3);
		chk1("eod_req", 1'h1, eod_req);
		pulse(2);
		chk1("eod_req", 1'h0, eod_req);
		wr_reg(ADDR_CTRL_TWO, 8'h08);
		pulse(4);
		chk1("eod_req", 1'h0, eod_req);
		@(posedge clk);
		ifr_active <= 1'h0;
	endtask : t_eod
	task t_loop(input logic [7:0] m);
		int n;
		wr_reg(ADDR_CTRL_TWO, m);
		cycles(2);
		chk1("bus_drive_en", 1'h0, bus_drive_en);
		chk1("analog_loop", m[7], analog_loop_out);
		@(posedge clk);
		engine_tx_bit <= 1'h1;
		cycles(6);
		chk1("rx loop", 1'h1, engine_rx_bit);
		@(posedge clk);
		engine_tx_bit <= 1'h0;
		node_drive <= 1'h1;
		cycles(6);
		chk1("rx bus", 1'h0, engine_rx_bit);
		@(posedge clk);
		node_drive <= 1'h0;
		wr_reg(ADDR_CTRL_TWO, 8'h00);
		wait_sig(1'h1, n);
		chk1("tx hold min", 1'h1, n >= (IFS_TICKS_INT - 1) * 8);
		chk1("tx hold max", 1'h1, n <= (IFS_TICKS_INT + 2) * 8);
		chk1("rx_enable", 1'h1, rx_enable);
	endtask : t_loop
	task t_brk;
		wr_reg(ADDR_CTRL_TWO, 8'h20);
		cycles(2);
		chk1("fast_rx", 1'h1, fast_rx_mode);
		chk1("tx_enable", 1'h0, tx_enable);
		pulse(1);
		cycles(1);
		chk1("fast_rx", 1'h0, fast_rx_mode);
		rd_reg(ADDR_STATE_VEC, SV_BREAK);
	endtask : t_brk
	task t_norm;
		for (int f = 0; f < 2; f++) begin
			for (int c = 0; c < 2; c++) begin
				wr_reg(ADDR_CTRL_TWO, 8'(f << 4));
				@(posedge clk);
				ifr_with_crc <= 1'(c);
				cycles(3);
				chk1("norm_bit", 1'(f ^ c), norm_bit);
			end
		end
	endtask : t_norm
	task t_ign;
		wr_reg(ADDR_CTRL_ONE, 8'h82);
		cycles(2);
		chk1("rx_enable", 1'h0, rx_enable);
		@(posedge clk);
		sv_evt_code <= SV_BREAK;
		pulse(6);
		cycles(2);
		chk1("irq", 1'h0, irq);
		rd_reg(ADDR_STATE_VEC, SV_NONE);
		pulse(0);
		cycles(2);
		chk1("rx_enable", 1'h1, rx_enable);
		rd_reg(ADDR_CTRL_ONE, 8'h0E);
		pulse(6);
		cycles(2);
		chk1("irq", 1'h1, irq);
		rd_reg(ADDR_STATE_VEC, SV_BREAK);
		cycles(2);
		chk1("irq", 1'h0, irq);
		wr_reg(ADDR_CTRL_ONE, 8'h00);
		pulse(6);
		cycles(2);
		chk1("irq", 1'h0, irq);
		rd_reg(ADDR_STATE_VEC, SV_BREAK);
	endtask : t_ign
	task t_wait(input logic [7:0] c1, input logic [7:0] e);
		int k;
		wr_reg(ADDR_CTRL_ONE, c1);
		@(posedge clk);
		cpu_wait <= 1'h1;
		cycles(3);
		count_ticks(k);
		chk8("ticks", e, 8'(k));
		@(posedge clk);
		node_drive <= 1'h1;
		repeat (4) @(posedge clk);
		node_drive <= 1'h0;
		repeat (4) @(posedge clk);
		cpu_wait <= 1'h0;
	endtask : t_wait
	initial begin
		t_rate();
		t_eod();
		t_loop(8'h40);
		t_loop(8'h80);
		t_brk();
		t_norm();
		t_ign();
		t_wait(8'h01, 8'h00);
		rd_reg(ADDR_STATE_VEC, SV_WAKEUP);
		wr_reg(ADDR_CTRL_TWO, 8'h40);
		t_wait(8'h01, 8'h00);
		rd_reg(ADDR_STATE_VEC, SV_NONE);
		t_wait(8'h00, 8'h02);
		test_done();
	end
endmodule : testbench
`default_nettype wire
